/* File: logic/dhi_pkg.sv */
// dhi_pkg: shared types and constants of the display host interface
// users: the dhi_top port block, which also sizes its fifo from it, and the testbench modules
package dhi_pkg;
    // ------------------------------------------------------------
    // interface mode, selected by static strap inputs
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DHI_M6800,                        // e strobe, r/w select
        DHI_M8080,                        // separate rd/wr strobes
        DHI_MSER,                         // clocked serial, write only
        DHI_MI2C                          // two-wire target
    } dhi_mode_t;

    // two-wire receiver states
    typedef enum logic [1:0] {
        DHI_I_IDLE,
        DHI_I_ADDR,
        DHI_I_CTRL,
        DHI_I_DATA
    } dhi_i2c_st_t;

    // one written byte with its command/data flag
    typedef struct packed {
        logic       dc;                   // 0 command, 1 display data
        logic [7:0] data;                 // the byte itself
    } dhi_xfer_t;

    // parallel pins as sampled
    typedef struct packed {
        logic       cs_n;                 // chip select, low active
        logic       stb_a;                // e (6800) or rd_n (8080)
        logic       stb_b;                // r/w (6800) or wr_n (8080)
        logic       dc;                   // command/data select
        logic [7:0] data;                 // data bus
    } dhi_pins_t;

    // ------------------------------------------------------------
    // sizes and positions
    // ------------------------------------------------------------
    localparam int          DHI_PIN_W     = 12;
    localparam int          DHI_XFER_W    = 9;
    localparam int          DHI_FIFO_DEPTH = 8;
    localparam logic [2:0]  DHI_SER_LAST  = 3'h7;  // eighth bit
    localparam logic [3:0]  DHI_I2C_ACKB  = 4'h8;  // ack bit slot
    localparam logic [3:0]  DHI_I2C_LAST  = 4'h7;
    localparam int          DHI_SCL_BIT   = 0;     // d0 is the clock
    localparam int          DHI_SDA_BIT   = 1;     // d1 is data
    localparam int          DHI_CO_BIT    = 7;     // control: continue
    localparam int          DHI_DC_BIT    = 6;     // control: data flag
    localparam logic [7:0]  DHI_OE_SDA    = 8'h02;
    localparam logic [7:0]  DHI_OE_ALL    = 8'hFF;
    localparam logic [7:0]  DHI_OE_NONE   = 8'h00;
    // arbitrary neutral upper six bits of the two-wire address
    localparam logic [5:0]  DHI_I2C_ADDR_HI = 6'h15;
endpackage

/* File: logic/dhi_top.sv */
// dhi_top: host access port of a display controller, all four modes,
// with a byte fifo toward the command/display-ram core.
// assumes mode straps static while running, serial_clk wired to d0.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// fifo
// ----------------------------------------------------------------
module dhi_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    // pointer arithmetic assumes a power of two
    if ((DEPTH < 2) || ((1 << AW) != DEPTH)) begin : g_bad_depth
        $error("dhi_fifo depth must be a power of two");
    end

    logic [W-1:0] mem [DEPTH];            // storage words
    logic [AW:0]  wp_q;                   // write pointer, wrap bit
    logic [AW:0]  rp_q;                   // read pointer, wrap bit
    wire          push = in_valid & in_ready;
    wire          pop  = out_valid & out_ready;

    // full when wrap bits differ and indices match
    assign in_ready  = !((wp_q[AW] != rp_q[AW]) &&
                         (wp_q[AW-1:0] == rp_q[AW-1:0]));
    assign out_valid = (wp_q != rp_q);
    assign out_data  = mem[rp_q[AW-1:0]];

    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_q + (AW+1)'(push);
            rp_q <= rp_q + (AW+1)'(pop);
        end
    end
endmodule // dhi_fifo

// ----------------------------------------------------------------
// top
// ----------------------------------------------------------------
module dhi_top (
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic              serial_clk,
    input  wire dhi_pkg::dhi_mode_t bus_mode,
    input  wire logic              addr_select_pin,
    input  wire logic              cs_n,
    input  wire logic              dc,
    input  wire logic              rw_wr_n,
    input  wire logic              e_rd_n,
    input  wire logic [7:0]        db_in,
    output logic [7:0]             db_out,
    output logic [7:0]             db_oe,
    output logic                   wr_valid,
    input  wire logic              wr_ready,
    output dhi_pkg::dhi_xfer_t     wr_xfer,
    output logic                   host_busy,
    input  wire logic [7:0]        status_in,
    input  wire logic [7:0]        rdata_in,
    output logic                   rd_done,
    output logic                   rd_dc
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic rise(input logic was, input logic now);
        return !was && now;
    endfunction

    function automatic logic fall(input logic was, input logic now);
        return was && !now;
    endfunction

    // ------------------------------------------------------------
    // pin synchroniser, three stages, change needs 2nd == 3rd
    // ------------------------------------------------------------
    dhi_pkg::dhi_pins_t raw_pins;
    logic [dhi_pkg::DHI_PIN_W-1:0] s1_q;   // first stage, read by s2 only
    logic [dhi_pkg::DHI_PIN_W-1:0] s2_q;
    logic [dhi_pkg::DHI_PIN_W-1:0] s3_q;
    logic [dhi_pkg::DHI_PIN_W-1:0] flt_q;  // agreed level
    dhi_pkg::dhi_pins_t cur;               // filtered now
    dhi_pkg::dhi_pins_t prv_q;             // filtered, one cycle back

    assign raw_pins = '{cs_n: cs_n, stb_a: e_rd_n, stb_b: rw_wr_n,
                        dc: dc, data: db_in};
    assign cur      = dhi_pkg::dhi_pins_t'(flt_q);

    for (genvar i = 0; i < dhi_pkg::DHI_PIN_W; i++) begin : g_sync
        // each bit filtered alone; idle levels high for strobes
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                s1_q[i]  <= 1'b1;
                s2_q[i]  <= 1'b1;
                s3_q[i]  <= 1'b1;
                flt_q[i] <= 1'b1;
            end else begin
                s1_q[i] <= raw_pins[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i]) begin
                    flt_q[i] <= s3_q[i];
                end
            end
        end
    end

    // previous filtered copy for edge finding
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prv_q <= '1;
        end else begin
            prv_q <= cur;
        end
    end

    // ------------------------------------------------------------
    // parallel decode
    // ------------------------------------------------------------
    // mode straps gate
    wire is_6800 = (bus_mode == dhi_pkg::DHI_M6800);
    wire is_8080 = (bus_mode == dhi_pkg::DHI_M8080);
    wire is_ser  = (bus_mode == dhi_pkg::DHI_MSER);
    wire is_i2c  = (bus_mode == dhi_pkg::DHI_MI2C);

    wire sel_68   = is_6800 && !cur.cs_n && !prv_q.cs_n;
    wire e_fall   = sel_68 && fall(prv_q.stb_a, cur.stb_a);
    wire wr_68    = e_fall && !cur.stb_b;
    wire rd_68    = e_fall && cur.stb_b;
    wire drv_68   = is_6800 && !cur.cs_n && cur.stb_b && cur.stb_a;

    wire sel_80   = is_8080 && !cur.cs_n && !prv_q.cs_n;
    wire cs_rise  = is_8080 && rise(prv_q.cs_n, cur.cs_n);
    wire wr_80s   = sel_80 && rise(prv_q.stb_b, cur.stb_b);
    wire rd_80s   = sel_80 && rise(prv_q.stb_a, cur.stb_a);
    wire wr_80c   = cs_rise && !prv_q.stb_b && prv_q.stb_a;
    wire rd_80c   = cs_rise && !prv_q.stb_a && prv_q.stb_b;
    wire drv_80   = is_8080 && !cur.cs_n && !cur.stb_a;

    wire par_wr   = wr_68 || wr_80s || wr_80c;
    wire par_rd   = rd_68 || rd_80s || rd_80c;
    // data and dc as seen before the latching edge
    wire par_dc   = prv_q.dc;

    // ------------------------------------------------------------
    // serial shifter, serial clock domain
    // ------------------------------------------------------------
    logic [2:0]         sbit_q;           // bits taken in this byte
    logic [6:0]         ssh_q;            // bits so far, msb first
    dhi_pkg::dhi_xfer_t sbyte_q;          // completed byte, held
    logic               stog_q;           // flips per byte

    // nothing driven here: serial has no read path
    always_ff @(posedge serial_clk or negedge rst_b) begin
        if (!rst_b) begin
            sbit_q  <= '0;
            ssh_q   <= '0;
            sbyte_q <= '0;
            stog_q  <= 1'b0;
        end else if (!is_ser || cs_n) begin
            // deselect restarts byte framing
            sbit_q <= '0;
        end else begin
            ssh_q <= {ssh_q[5:0], db_in[dhi_pkg::DHI_SDA_BIT]};
            if (sbit_q == dhi_pkg::DHI_SER_LAST) begin
                sbyte_q <= '{dc: dc,
                             data: {ssh_q, db_in[dhi_pkg::DHI_SDA_BIT]}};
                stog_q  <= !stog_q;
                sbit_q  <= '0;
            end else begin
                sbit_q <= sbit_q + 3'h1;
            end
        end
    end

    // toggle crossing; byte register stable for eight serial clocks
    logic t1_q;                           // first stage, read by t2 only
    logic t2_q;
    logic t3_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            t1_q <= 1'b0;
            t2_q <= 1'b0;
            t3_q <= 1'b0;
        end else begin
            t1_q <= stog_q;
            t2_q <= t1_q;
            t3_q <= t2_q;
        end
    end

    wire ser_wr = is_ser && (t2_q != t3_q);

    // ------------------------------------------------------------
    // two-wire target
    // ------------------------------------------------------------
    dhi_pkg::dhi_i2c_st_t ist_q;          // frame position
    logic [3:0]           icnt_q;         // bit slot in byte
    logic [7:0]           ish_q;          // shift register
    logic                 iack_q;         // ack owed for this byte
    logic                 ico_q;          // one byte then control
    logic                 idc_q;          // data flag from control
    logic                 isda_oe_q;      // pulling sda low
    logic                 i2c_wr_q;       // byte push pulse

    wire scl_p  = prv_q.data[dhi_pkg::DHI_SCL_BIT];
    wire scl_c  = cur.data[dhi_pkg::DHI_SCL_BIT];
    wire sda_p  = prv_q.data[dhi_pkg::DHI_SDA_BIT];
    wire sda_c  = cur.data[dhi_pkg::DHI_SDA_BIT];
    wire i_strt = is_i2c && scl_c && scl_p && fall(sda_p, sda_c);
    wire i_stop = is_i2c && scl_c && scl_p && rise(sda_p, sda_c);
    wire i_rise = is_i2c && rise(scl_p, scl_c);
    wire i_fall = is_i2c && fall(scl_p, scl_c);
    wire [7:0] i_byte = {ish_q[6:0], sda_c};
    wire [6:0] i_addr = {dhi_pkg::DHI_I2C_ADDR_HI, addr_select_pin};
    wire       i_last = (icnt_q == dhi_pkg::DHI_I2C_LAST);

    // receiver; acks only writes to our address
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ist_q     <= dhi_pkg::DHI_I_IDLE;
            icnt_q    <= '0;
            ish_q     <= '0;
            iack_q    <= 1'b0;
            ico_q     <= 1'b0;
            idc_q     <= 1'b0;
            isda_oe_q <= 1'b0;
            i2c_wr_q  <= 1'b0;
        end else begin
            i2c_wr_q <= 1'b0;
            if (!is_i2c || i_stop) begin
                ist_q     <= dhi_pkg::DHI_I_IDLE;
                isda_oe_q <= 1'b0;
            end else if (i_strt) begin
                // repeated start also lands here
                ist_q     <= dhi_pkg::DHI_I_ADDR;
                icnt_q    <= '0;
                isda_oe_q <= 1'b0;
            end else if (i_fall) begin
                // ack driven across the ninth clock only
                isda_oe_q <= iack_q && (icnt_q == dhi_pkg::DHI_I2C_ACKB);
            end else if (i_rise && ist_q != dhi_pkg::DHI_I_IDLE) begin
                if (icnt_q == dhi_pkg::DHI_I2C_ACKB) begin
                    icnt_q <= '0;
                    iack_q <= 1'b0;
                end else begin
                    ish_q  <= i_byte;
                    icnt_q <= icnt_q + 4'h1;
                end
                if (i_last) begin
                    case (ist_q)
                        dhi_pkg::DHI_I_ADDR: begin
                            // write direction and our address only
                            if (i_byte == {i_addr, 1'b0}) begin
                                ist_q  <= dhi_pkg::DHI_I_CTRL;
                                iack_q <= 1'b1;
                            end else begin
                                ist_q <= dhi_pkg::DHI_I_IDLE;
                            end
                        end
                        dhi_pkg::DHI_I_CTRL: begin
                            ico_q  <= i_byte[dhi_pkg::DHI_CO_BIT];
                            idc_q  <= i_byte[dhi_pkg::DHI_DC_BIT];
                            ist_q  <= dhi_pkg::DHI_I_DATA;
                            iack_q <= 1'b1;
                        end
                        dhi_pkg::DHI_I_DATA: begin
                            i2c_wr_q <= 1'b1;
                            iack_q   <= 1'b1;
                            if (ico_q) begin
                                ist_q <= dhi_pkg::DHI_I_CTRL;
                            end
                        end
                        default: begin
                            ist_q <= dhi_pkg::DHI_I_IDLE;
                        end
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // write path into fifo
    // ------------------------------------------------------------
    dhi_pkg::dhi_xfer_t in_x;             // chosen source
    dhi_pkg::dhi_xfer_t f_out;
    logic               in_v;
    logic               f_rdy;
    logic               f_v;
    logic               f_pop;

    assign in_v = par_wr || ser_wr || i2c_wr_q;
    assign in_x = ser_wr   ? sbyte_q :
                  i2c_wr_q ? '{dc: idc_q, data: ish_q} :
                             '{dc: par_dc, data: prv_q.data};
    // refill output stage when empty or being taken
    assign f_pop = f_v && (!wr_valid || wr_ready);

    dhi_fifo #(
        .W     (dhi_pkg::DHI_XFER_W),
        .DEPTH (dhi_pkg::DHI_FIFO_DEPTH)
    ) u_fifo (
        .clk       (sys_clk),
        .rst_b     (rst_b),
        .in_valid  (in_v),
        .in_ready  (f_rdy),
        .in_data   (in_x),
        .out_valid (f_v),
        .out_ready (f_pop),
        .out_data  (f_out)
    );

    // output stage; host must watch host_busy, a full fifo drops bytes
    // reset clears outputs
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_valid  <= 1'b0;
            wr_xfer   <= '0;
            host_busy <= 1'b0;
        end else begin
            host_busy <= !f_rdy;
            if (f_pop) begin
                wr_valid <= 1'b1;
                wr_xfer  <= f_out;
            end else if (wr_ready) begin
                wr_valid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read path and bus drive
    // ------------------------------------------------------------
    wire       drv_par = drv_68 || drv_80;
    wire [7:0] rd_byte = cur.dc ? rdata_in : status_in;

    // bus driven while the read strobe is active
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            db_out  <= '0;
            db_oe   <= dhi_pkg::DHI_OE_NONE;
            rd_done <= 1'b0;
            rd_dc   <= 1'b0;
        end else begin
            rd_done <= par_rd;
            rd_dc   <= par_dc;
            if (drv_par) begin
                db_out <= rd_byte;
                db_oe  <= dhi_pkg::DHI_OE_ALL;
            end else if (isda_oe_q) begin
                db_out <= '0;
                db_oe  <= dhi_pkg::DHI_OE_SDA;
            end else begin
                db_out <= '0;
                db_oe  <= dhi_pkg::DHI_OE_NONE;
            end
        end
    end
endmodule // dhi_top

/* File: testbench/dhi_monitor.sv */
// dhi_monitor: concurrent checks on the ports of dhi_top
// assumes only sys_clk-domain outputs are watched; straps held static
`timescale 1ns/1ps
module dhi_monitor (
    input wire logic               sys_clk,
    input wire logic               rst_b,
    input wire dhi_pkg::dhi_mode_t bus_mode,
    input wire logic               cs_n,
    input wire logic               rw_wr_n,
    input wire logic               e_rd_n,
    input wire logic [7:0]         db_oe,
    input wire logic               wr_valid,
    input wire logic               wr_ready,
    input wire dhi_pkg::dhi_xfer_t wr_xfer,
    input wire logic               rd_done
);
    logic [3:0] quiet_q;                  // cycles with chip select high
    logic [3:0] quiet_d;
    logic       par;                      // a parallel mode is strapped
    assign par = bus_mode inside {dhi_pkg::DHI_M6800, dhi_pkg::DHI_M8080};
    // saturate so a long idle never wraps back below the limit
    assign quiet_d = cs_n ? quiet_q + {3'h0, quiet_q != 4'hF} : 4'h0;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            quiet_q <= 4'h0;
        else
            quiet_q <= quiet_d;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_stall; wr_valid && !wr_ready; endsequence
    sequence s_kept; wr_valid && $stable(wr_xfer); endsequence
    property p_hold; s_stall |=> s_kept; endproperty
    a_hold: assert property (p_hold) else $error("stalled byte lost");
    property p_rst; disable iff (1'b0)
        !rst_b |-> db_oe == 8'h00 && !wr_valid && !rd_done; endproperty
    a_rst: assert property (p_rst) else $error("active in reset");
    property p_cs_ign; quiet_q >= 4'hA |-> !rd_done; endproperty
    a_cs_ign: assert property (p_cs_ign) else $error("read unselected");
    property p_cs_oe; quiet_q >= 4'hA && par |-> db_oe == 8'h00; endproperty
    a_cs_oe: assert property (p_cs_oe) else $error("drives unselected");
    property p_rw; (bus_mode == dhi_pkg::DHI_M6800 && !rw_wr_n) [*8]
        |-> db_oe == 8'h00; endproperty
    a_rw: assert property (p_rw) else $error("drives in write");
    property p_rd80; (bus_mode == dhi_pkg::DHI_M8080 && e_rd_n) [*8]
        |-> db_oe == 8'h00; endproperty
    a_rd80: assert property (p_rd80) else $error("drives, rd high");
    property p_ser; bus_mode == dhi_pkg::DHI_MSER
        |-> db_oe == 8'h00 && !rd_done; endproperty
    a_ser: assert property (p_ser) else $error("serial read");
    property p_i2c; bus_mode == dhi_pkg::DHI_MI2C
        |-> db_oe == 8'h00 || db_oe == 8'h02; endproperty
    a_i2c: assert property (p_i2c) else $error("bad two-wire drive");
    property p_pulse; rd_done |=> !rd_done; endproperty
    a_pulse: assert property (p_pulse) else $error("read done long");
    property p_rdmode; rd_done |-> par; endproperty
    a_rdmode: assert property (p_rdmode) else $error("read bad mode");
endmodule // dhi_monitor
bind dhi_top dhi_monitor mon_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .bus_mode(bus_mode), .cs_n(cs_n), .rw_wr_n(rw_wr_n), .e_rd_n(e_rd_n),
    .db_oe(db_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_xfer(wr_xfer), .rd_done(rd_done));

/* File: testbench/dhi_host_model.sv */
// dhi_host_model: behavioural host processor on the display port pins
// assumes the bench merges its bus with the device drivers into db_in
`timescale 1ns/1ps
module dhi_host_model (
    input  wire logic               sys_clk,
    input  wire dhi_pkg::dhi_mode_t m,
    input  wire logic [7:0]         db_in,
    output logic                    cs_n,
    output logic                    dc,
    output logic                    rw_wr_n,
    output logic                    e_rd_n,
    output logic [7:0]              hdb
);
    initial begin
        cs_n = 1'b1;
        dc = 1'b0;
        rw_wr_n = 1'b1;
        e_rd_n = 1'b0;
        hdb = 8'h00;
    end
    task automatic nw(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // idle levels; pulled-up lines high in two-wire mode
    task automatic idle();
        cs_n = 1'b1;
        rw_wr_n = (m != dhi_pkg::DHI_MSER);
        e_rd_n = (m == dhi_pkg::DHI_M8080);
        hdb = (m == dhi_pkg::DHI_MI2C) ? 8'hFF : 8'h00;
    endtask
    // one byte per strobe, c is the chip-select level; with alt (ignored in 6800 mode), cs_n itself is the write strobe and c is unused
    task automatic w(input logic d, input logic [7:0] b, input logic c,
                     input logic alt);
        dc = d;
        hdb = b;
        if (m == dhi_pkg::DHI_M6800) begin
            rw_wr_n = 1'b0;
            cs_n = c;
            nw(4);
            e_rd_n = 1'b1;
            nw(4);
            e_rd_n = 1'b0;
        end else if (alt) begin
            rw_wr_n = 1'b0;
            nw(4);
            cs_n = 1'b0;
            nw(5);
            cs_n = 1'b1;
        end else begin
            cs_n = c;
            nw(4);
            rw_wr_n = 1'b0;
            nw(4);
            rw_wr_n = 1'b1;
        end
        nw(4);
        idle();
        nw(6);
    endtask
    // host bus inverted, byte taken as the read strobe ends
    task automatic r(input logic d, input logic alt, output logic [7:0] b);
        dc = d;
        hdb = ~hdb;
        cs_n = alt;
        e_rd_n = (m == dhi_pkg::DHI_M8080) ? alt : 1'b0;
        nw(4);
        if (m == dhi_pkg::DHI_M6800)
            e_rd_n = 1'b1;
        else
            {cs_n, e_rd_n} = 2'h0;
        nw(10);
        b = db_in;
        if (alt)
            cs_n = 1'b1;
        else
            e_rd_n = (m == dhi_pkg::DHI_M8080);
        nw(4);
        idle();
        nw(6);
    endtask
    // scl on d0, sda on d1+d2, ack slots released, never read
    task automatic i2c(input logic [26:0] v);
        hdb[2:1] = 2'h0;
        nw(4);
        for (int i = 26; i >= 0; i--) begin
            hdb[0] = 1'b0;
            hdb[2:1] = {2{v[i]}};
            nw(8);
            hdb[0] = 1'b1;
            nw(4);
        end
        hdb[0] = 1'b0;
        hdb[2:1] = 2'h0;
        nw(8);
        hdb[0] = 1'b1;
        nw(4);
        hdb[2:1] = 2'h3;
        nw(6);
    endtask
    // write only, 12 ns clock on d0, msb first, dc held
    task automatic s(input logic d, input logic [7:0] b);
        dc = d;
        cs_n = 1'b0;
        #23;
        for (int i = 7; i >= 0; i--) begin
            hdb[1] = b[i];
            #6 hdb[0] = 1'b1;
            #6 hdb[0] = 1'b0;
        end
        #20 cs_n = 1'b1;
        hdb[1] = ~hdb[1];
        nw(10);
    endtask
endmodule // dhi_host_model

/* File: testbench/test_display_host_interface.sv */
// test_display_host_interface: self-checking bench for dhi_top
// assumes dhi_pkg, dhi_top, dhi_host_model and dhi_monitor compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    n_errors++; $display("unexpected at %0t: %h not %h", $time, a, b); end end
module test_display_host_interface;
    logic               sys_clk = 1'b0;
    logic               rst_b = 1'b0;
    logic               wr_ready = 1'b1;
    dhi_pkg::dhi_mode_t bus_mode = dhi_pkg::DHI_M6800;
    logic [7:0]         status_in = 8'h5A;  // status byte from core
    logic [7:0]         rdata_in = 8'hC3;   // ram byte from core
    logic               cs_n, dc, rw_wr_n, e_rd_n, wr_valid, host_busy;
    logic               rd_done, rd_dc, last_dc;
    logic [7:0]         hdb, db_in, db_out, db_oe;
    dhi_pkg::dhi_xfer_t wr_xfer;
    dhi_pkg::dhi_xfer_t q[$];               // bytes taken by the core
    int                 n_errors = 0, samples_checked = 0, n_rd = 0, cyc = 0;
    // device wins each bit it enables, host otherwise
    assign db_in = (db_oe & db_out) | (~db_oe & hdb);
    always #2.5 sys_clk = ~sys_clk;
    dhi_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .serial_clk(hdb[0]),
        .bus_mode(bus_mode), .addr_select_pin(1'b0), .cs_n(cs_n), .dc(dc),
        .rw_wr_n(rw_wr_n), .e_rd_n(e_rd_n), .db_in(db_in), .db_out(db_out),
        .db_oe(db_oe), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_xfer(wr_xfer), .host_busy(host_busy), .status_in(status_in),
        .rdata_in(rdata_in), .rd_done(rd_done), .rd_dc(rd_dc));
    dhi_host_model host_u (.sys_clk(sys_clk), .m(bus_mode), .db_in(db_in),
        .cs_n(cs_n), .dc(dc), .rw_wr_n(rw_wr_n), .e_rd_n(e_rd_n), .hdb(hdb));
    // core side: collect accepted bytes, count finished reads
    always @(posedge sys_clk) begin
        cyc++;
        if (wr_valid === 1'b1 && wr_ready)
            q.push_back(wr_xfer);
        if (rd_done === 1'b1) begin
            n_rd++;
            last_dc = rd_dc;
        end
        if (cyc == 60000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // restrap under reset; straps only change while reset is held
    task automatic reboot(input dhi_pkg::dhi_mode_t m);
        @(negedge sys_clk);
        rst_b = 1'b0;
        bus_mode = m;
        #1 host_u.idle();
        repeat (12) @(negedge sys_clk);
        `CHK({db_oe, wr_valid, rd_done}, 10'h000)
        rst_b = 1'b1;
        q.delete();
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic expect_byte(input logic d, input logic [7:0] b);
        dhi_pkg::dhi_xfer_t x;
        for (int k = 0; k < 80 && q.size() == 0; k++) @(negedge sys_clk);
        x = (q.size() == 0) ? 'x : q.pop_front();
        `CHK(x, {d, b})
    endtask
    task automatic t_par(input dhi_pkg::dhi_mode_t m);
        logic [7:0] b;
        int         n0;
        reboot(m);
        host_u.w(1'b0, 8'hA5, 1'b0, 1'b0);
        host_u.w(1'b1, 8'h3C, 1'b0, 1'b0);
        expect_byte(1'b0, 8'hA5);
        expect_byte(1'b1, 8'h3C);
        host_u.w(1'b1, 8'h77, 1'b1, 1'b0);
        repeat (40) @(negedge sys_clk);
        `CHK(q.size(), 0)
        n0 = n_rd;
        host_u.r(1'b0, 1'b0, b);
        `CHK(b, 8'h5A)
        host_u.r(1'b1, 1'b0, b);
        `CHK(b, 8'hC3)
        `CHK({n_rd - n0, last_dc}, {32'd2, 1'b1})
        if (m == dhi_pkg::DHI_M8080) begin
            host_u.w(1'b1, 8'h81, 1'b0, 1'b1);
            expect_byte(1'b1, 8'h81);
            host_u.r(1'b0, 1'b1, b);
            `CHK({b, last_dc}, {8'h5A, 1'b0})
        end
    endtask
    // full buffer drops later bytes; drained order must be kept
    task automatic t_fifo();
        reboot(dhi_pkg::DHI_M6800);
        wr_ready = 1'b0;
        for (int k = 0; k < 10; k++) host_u.w(1'b1, 8'(k), 1'b0, 1'b0);
        `CHK(host_busy, 1'b1)
        wr_ready = 1'b1;
        for (int k = 0; k < 8; k++) expect_byte(1'b1, 8'(k));
        expect_byte(1'b1, 8'h08);
        repeat (20) @(negedge sys_clk);
        `CHK(q.size(), 0)
    endtask
    // setup order stays the host's duty
    task automatic t_i2c();
        reboot(dhi_pkg::DHI_MI2C);
        repeat (20) @(negedge sys_clk);
        `CHK({db_oe, q.size()}, 40'h0)
        host_u.i2c({dhi_pkg::DHI_I2C_ADDR_HI, 3'h1, 8'h40, 1'b1,
                    8'h96, 1'b1});
        expect_byte(1'b1, 8'h96);
    endtask
    task automatic t_ser();
        reboot(dhi_pkg::DHI_MSER);
        host_u.s(1'b0, 8'hB4);
        host_u.s(1'b1, 8'h2D);
        expect_byte(1'b0, 8'hB4);
        expect_byte(1'b1, 8'h2D);
    endtask
    initial begin
        t_par(dhi_pkg::DHI_M6800);
        t_par(dhi_pkg::DHI_M8080);
        t_fifo();
        t_ser();
        t_i2c();
        end_sim();
    end
endmodule // test_display_host_interface
